/* shared/igsf_defs.svh */
// Constants for the interrupt group security filter: sizes, reset values.
// Assumes inclusion by bare name from design files that also import igsf_pkg.
//
// Contract
// - Non-secure read of a Secure interrupt's field returns zero.
// - Non-secure write to a Secure interrupt's field changes nothing.
// - Secure accesses reach all interrupts; Non-secure only Non-secure ones.
// - Group 0 interrupts are Secure, group 1 interrupts are Non-secure.
// - Secure software sets a group bit for every implemented interrupt.
// - Non-secure interrupts use only the normal request line.
// - Secure interrupts use normal or fast line, chosen by configuration.
// - Grouping and fast signalling of group 0 are always present.
// - Each interrupt keeps inactive, pending, active or both per processor.
// - Pending on asserted source or software set, until serviced.
// - Acknowledge makes an interrupt active until its completion.
// - A new request during service gives active and pending.
// - A private interrupt reaches only its own processor's interface.
// - A shared interrupt routes to any configured set of processors.
// - Completion may split into priority drop and later deactivation.
// - Bypass disables block legacy lines while forwarding is off.
// - Interrupt state is writable so it can be saved and restored.
// - Pending interrupts for a sleeping processor raise a wakeup.
// - Edge interrupts latch on a rising edge and stay until cleared.
// - Level interrupts follow the input; deassertion removes pending.
`ifndef IGSF_DEFS_SVH
`define IGSF_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define IGSF_N_CPU 2
`define IGSF_N_PRIV 4
`define IGSF_N_SPI 8
`define IGSF_IDW 5
`define IGSF_DW 8

// ****************************************
// Reset values
// ****************************************
`define IGSF_GRP_RST 1'b0
`define IGSF_EN_RST 1'b0
`define IGSF_EDGE_RST 1'b0
`define IGSF_TGT_RST 1'b0

`endif

/* shared/igsf_pkg.sv */
// Types shared by the interrupt group security filter and its slots.
// Assumes nothing beyond a SystemVerilog compiler.
package igsf_pkg;

  // Bit 1 active, bit 0 pending
  typedef enum logic [1:0] {
    IGSF_ST_INACTIVE = 2'b00,
    IGSF_ST_PENDING = 2'b01,
    IGSF_ST_ACTIVE = 2'b10,
    IGSF_ST_ACT_PEND = 2'b11
  } igsf_state_t;

  typedef enum logic [2:0] {
    IGSF_FLD_GROUP = 3'b000,
    IGSF_FLD_ENABLE = 3'b001,
    IGSF_FLD_EDGE = 3'b010,
    IGSF_FLD_TARGET = 3'b011,
    IGSF_FLD_PEND_SET = 3'b100,
    IGSF_FLD_PEND_CLR = 3'b101,
    IGSF_FLD_STATE = 3'b110
  } igsf_fld_t;

  typedef struct packed {
    igsf_state_t st;
    logic src_prev;
  } igsf_slot_t;

endpackage

/* rtl/igsf_irq_slot.sv */
// One interrupt as seen at one processor interface.
// Assumes i_src is already synchronised and masked by routing.
`timescale 1ns/1ps
module igsf_irq_slot import igsf_pkg::*; (
  // Clock and reset
  input logic i_clk_sys,
  input logic i_srst,
  // Source and configuration
  input logic i_src,
  input logic i_edge,
  // Events
  input logic i_sw_set,
  input logic i_sw_clr,
  input logic i_ack,
  input logic i_deact,
  input logic i_wr,
  input igsf_state_t i_wr_state,
  // State
  output igsf_state_t o_state
);

  igsf_slot_t q;
  igsf_slot_t d;
  logic rise;
  logic fall;
  logic p0;
  logic p_n;
  logic a_n;

  always_comb begin
    d = q;
    d.src_prev = i_src;
    rise = i_src & ~q.src_prev;
    fall = ~i_src & q.src_prev;
    p0 = q.st[0] & ~i_ack & ~i_sw_clr;
    a_n = (q.st[1] | (i_ack & q.st[0])) & ~i_deact;
    if (i_edge) begin
      p_n = p0 | rise | i_sw_set;
    end else begin
      p_n = (p0 & ~fall) | i_src | i_sw_set;
    end
    if (i_wr) begin
      d.st = i_wr_state;
    end else begin
      d.st = igsf_state_t'({a_n, p_n});
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '{st: IGSF_ST_INACTIVE, src_prev: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_state = q.st;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  a_edge_latch: assert property (i_edge && rise && !i_wr |=> o_state[0])
    else $error("edge not latched");
  a_level_drop: assert property (
    !i_edge && fall && !i_sw_set && !i_wr |=> !o_state[0])
    else $error("level pending not removed");
  a_ack_active: assert property (
    i_ack && o_state[0] && !i_deact && !i_wr |=> o_state[1])
    else $error("ack did not activate");
  a_act_pend: assert property (
    o_state == IGSF_ST_ACTIVE && i_edge && rise && !i_deact && !i_wr
    |=> o_state == IGSF_ST_ACT_PEND)
    else $error("new request lost during service");

endmodule

/* rtl/igsf_filter.sv */
// Interrupt grouping, security filtering and request line routing.
// Assumes same-clock logic drives access, control and handshake ports;
// interrupt sources and legacy lines arrive asynchronously.
`timescale 1ns/1ps
`include "igsf_defs.svh"
module igsf_filter import igsf_pkg::*; #(
  parameter int N_CPU = `IGSF_N_CPU,
  parameter int N_PRIV = `IGSF_N_PRIV,
  parameter int N_SPI = `IGSF_N_SPI,
  parameter int IDW = `IGSF_IDW,
  parameter int DW = `IGSF_DW,
  parameter int CW = (N_CPU > 1) ? $clog2(N_CPU) : 1
) (
  // Clock and reset
  input logic i_clk_sys,
  input logic i_srst,
  // Interrupt sources
  input logic [N_CPU*N_PRIV-1:0] i_priv_src,
  input logic [N_SPI-1:0] i_spi_src,
  // Legacy lines
  input logic [N_CPU-1:0] i_legacy_irq,
  input logic [N_CPU-1:0] i_legacy_fast,
  // Controls
  input logic i_dist_en,
  input logic [N_CPU-1:0] i_cpu_en_grp0,
  input logic [N_CPU-1:0] i_cpu_en_grp1,
  input logic [N_CPU-1:0] i_fast_en,
  input logic [N_CPU-1:0] i_irq_byp_dis,
  input logic [N_CPU-1:0] i_fast_byp_dis,
  input logic [N_CPU-1:0] i_eoi_split,
  input logic [N_CPU-1:0] i_cpu_sleep,
  // Field access
  input logic i_acc_valid,
  input logic i_acc_write,
  input logic i_acc_secure,
  input igsf_fld_t i_acc_fld,
  input logic [CW-1:0] i_acc_cpu,
  input logic [IDW-1:0] i_acc_id,
  input logic [DW-1:0] i_acc_wdata,
  output logic o_acc_rvalid,
  output logic [DW-1:0] o_acc_rdata,
  // Processor handshake
  input logic [N_CPU-1:0] i_ack,
  output logic [N_CPU-1:0] o_ack_valid,
  output logic [N_CPU*IDW-1:0] o_ack_id,
  input logic [N_CPU-1:0] i_eoi,
  input logic [N_CPU-1:0] i_deact,
  input logic [N_CPU*IDW-1:0] i_eoi_id,
  output logic [N_CPU-1:0] o_prio_drop,
  // Request lines
  output logic [N_CPU-1:0] o_irq,
  output logic [N_CPU-1:0] o_fast,
  output logic [N_CPU-1:0] o_wake
);

  localparam int NI = N_PRIV + N_SPI;
  localparam int NB = N_CPU * N_PRIV + N_SPI;
  localparam int NS = N_CPU * NI;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (N_CPU < 1 || N_SPI < 1 || N_PRIV < 1) begin : g_chk_size
    $error("igsf_filter: counts must be at least one");
  end
  if (NI >= (1 << IDW) - 1) begin : g_chk_idw
    $error("igsf_filter: IDW too narrow for ids and spurious code");
  end
  if (DW < 2 || DW < N_CPU) begin : g_chk_dw
    $error("igsf_filter: DW too narrow for state or target fields");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NB-1:0] grp;
    logic [NB-1:0] en;
    logic [NB-1:0] edge_cfg;
    logic [N_SPI*N_CPU-1:0] tgt;
    logic [NB-1:0] src_s1;
    logic [NB-1:0] src_s2;
    logic [N_CPU-1:0] lirq_s1;
    logic [N_CPU-1:0] lirq_s2;
    logic [N_CPU-1:0] lfast_s1;
    logic [N_CPU-1:0] lfast_s2;
    logic [N_CPU-1:0] irq;
    logic [N_CPU-1:0] fast;
    logic [N_CPU-1:0] wake;
    logic [N_CPU-1:0] drop;
    logic [N_CPU-1:0] ackv;
    logic [N_CPU*IDW-1:0] ack_id;
    logic [DW-1:0] rdata;
    logic rvalid;
  } igsf_st_t;

  localparam igsf_st_t RST = '{
    grp: {NB{`IGSF_GRP_RST}},
    en: {NB{`IGSF_EN_RST}},
    edge_cfg: {NB{`IGSF_EDGE_RST}},
    tgt: {(N_SPI*N_CPU){`IGSF_TGT_RST}},
    default: '0
  };

  igsf_st_t q;
  igsf_st_t d;

  // Slot controls and state
  logic [NS-1:0] sl_src;
  logic [NS-1:0] sl_edge;
  logic [NS-1:0] sl_set;
  logic [NS-1:0] sl_clr;
  logic [NS-1:0] sl_ack;
  logic [NS-1:0] sl_deact;
  logic [NS-1:0] sl_wr;
  logic [NS-1:0] rdy;
  igsf_state_t sl_state [NS];
  igsf_state_t wr_state;

  // Per-processor summaries and field access decode
  logic [N_CPU-1:0] hp0;
  logic [N_CPU-1:0] hp1;
  logic [N_CPU-1:0] pend_any;
  logic acc_grp1;
  logic acc_ok;
  logic acc_id_ok;

  // Storage index of the config bits of an interrupt at a processor
  function automatic int cfg_idx(input int cpu, input int id);
    if (id < N_PRIV) begin
      return cpu * N_PRIV + id;
    end
    return N_CPU * N_PRIV + (id - N_PRIV);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int ci;
    int si;
    int pick;
    int eid;
    logic [DW-1:0] rd;
    ci = 0;
    si = 0;
    pick = -1;
    eid = 0;
    rd = '0;
    d = q;
    d.src_s1 = {i_spi_src, i_priv_src};
    d.src_s2 = q.src_s1;
    d.lirq_s1 = i_legacy_irq;
    d.lirq_s2 = q.lirq_s1;
    d.lfast_s1 = i_legacy_fast;
    d.lfast_s2 = q.lfast_s1;
    sl_set = '0;
    sl_clr = '0;
    sl_ack = '0;
    sl_deact = '0;
    sl_wr = '0;
    wr_state = igsf_state_t'(i_acc_wdata[1:0]);
    hp0 = '0;
    hp1 = '0;
    pend_any = '0;

    // Routing into slots and readiness
    for (int c = 0; c < N_CPU; c++) begin
      for (int i = 0; i < NI; i++) begin
        ci = cfg_idx(c, i);
        si = c * NI + i;
        if (i < N_PRIV) begin
          sl_src[si] = q.src_s2[ci];
        end else begin
          sl_src[si] = q.src_s2[ci] & q.tgt[(i - N_PRIV) * N_CPU + c];
        end
        sl_edge[si] = q.edge_cfg[ci];
        rdy[si] = (sl_state[si] == IGSF_ST_PENDING) && q.en[ci] && i_dist_en &&
          (q.grp[ci] ? i_cpu_en_grp1[c] : i_cpu_en_grp0[c]);
        hp0[c] = hp0[c] | (rdy[si] & ~q.grp[ci]);
        hp1[c] = hp1[c] | (rdy[si] & q.grp[ci]);
        pend_any[c] = pend_any[c] | (sl_state[si][0] & q.en[ci] & i_dist_en);
      end
    end

    // Field access with security filter
    acc_id_ok = (int'(i_acc_id) < NI) && (int'(i_acc_cpu) < N_CPU);
    ci = cfg_idx(int'(i_acc_cpu), int'(i_acc_id));
    si = int'(i_acc_cpu) * NI + int'(i_acc_id);
    acc_grp1 = acc_id_ok ? q.grp[ci] : 1'b0;
    acc_ok = acc_id_ok && (i_acc_secure || acc_grp1);
    if (i_acc_valid && acc_ok) begin
      case (i_acc_fld)
        IGSF_FLD_GROUP: begin
          rd[0] = q.grp[ci];
          if (i_acc_write && i_acc_secure) begin
            d.grp[ci] = i_acc_wdata[0];
          end
        end
        IGSF_FLD_ENABLE: begin
          rd[0] = q.en[ci];
          if (i_acc_write) begin
            d.en[ci] = i_acc_wdata[0];
          end
        end
        IGSF_FLD_EDGE: begin
          rd[0] = q.edge_cfg[ci];
          if (i_acc_write) begin
            d.edge_cfg[ci] = i_acc_wdata[0];
          end
        end
        IGSF_FLD_TARGET: begin
          if (int'(i_acc_id) >= N_PRIV) begin
            rd[N_CPU-1:0] = q.tgt[(int'(i_acc_id) - N_PRIV) * N_CPU +: N_CPU];
            if (i_acc_write) begin
              d.tgt[(int'(i_acc_id) - N_PRIV) * N_CPU +: N_CPU] = i_acc_wdata[N_CPU-1:0];
            end
          end else begin
            rd[int'(i_acc_cpu)] = 1'b1;
          end
        end
        IGSF_FLD_PEND_SET: begin
          rd[0] = sl_state[si][0];
          sl_set[si] = i_acc_write & i_acc_wdata[0];
        end
        IGSF_FLD_PEND_CLR: begin
          rd[0] = sl_state[si][0];
          sl_clr[si] = i_acc_write & i_acc_wdata[0];
        end
        IGSF_FLD_STATE: begin
          rd[1:0] = sl_state[si];
          sl_wr[si] = i_acc_write;
        end
        default: begin
          rd = '0;
        end
      endcase
    end
    d.rvalid = i_acc_valid & ~i_acc_write;
    d.rdata = (i_acc_valid && !i_acc_write) ? rd : '0;

    // Acknowledge, completion and request lines
    for (int c = 0; c < N_CPU; c++) begin
      pick = -1;
      for (int i = NI - 1; i >= 0; i--) begin
        if (rdy[c * NI + i]) begin
          pick = i;
        end
      end
      d.ackv[c] = i_ack[c];
      if (i_ack[c]) begin
        if (pick >= 0) begin
          sl_ack[c * NI + pick] = 1'b1;
          d.ack_id[c*IDW +: IDW] = IDW'(pick);
        end else begin
          d.ack_id[c*IDW +: IDW] = {IDW{1'b1}};
        end
      end
      eid = int'(i_eoi_id[c*IDW +: IDW]);
      d.drop[c] = i_eoi[c];
      if (eid < NI && ((i_eoi[c] && !i_eoi_split[c]) || (i_deact[c] && i_eoi_split[c]))) begin
        sl_deact[c * NI + eid] = 1'b1;
      end
      if (i_cpu_en_grp0[c] || i_cpu_en_grp1[c]) begin
        d.irq[c] = hp1[c] | (hp0[c] & ~i_fast_en[c]);
      end else begin
        d.irq[c] = ~i_irq_byp_dis[c] & q.lirq_s2[c];
      end
      if (i_cpu_en_grp0[c] && i_fast_en[c]) begin
        d.fast[c] = hp0[c];
      end else if (!i_cpu_en_grp0[c]) begin
        d.fast[c] = ~i_fast_byp_dis[c] & q.lfast_s2[c];
      end else begin
        d.fast[c] = 1'b0;
      end
      d.wake[c] = i_cpu_sleep[c] & pend_any[c];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Slots
  // ****************************************
  for (genvar s = 0; s < NS; s++) begin : g_slot
    igsf_irq_slot u_slot (
      .i_clk_sys (i_clk_sys),
      .i_srst (i_srst),
      .i_src (sl_src[s]),
      .i_edge (sl_edge[s]),
      .i_sw_set (sl_set[s]),
      .i_sw_clr (sl_clr[s]),
      .i_ack (sl_ack[s]),
      .i_deact (sl_deact[s]),
      .i_wr (sl_wr[s]),
      .i_wr_state (wr_state),
      .o_state (sl_state[s])
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_acc_rvalid = q.rvalid;
  assign o_acc_rdata = q.rdata;
  assign o_ack_valid = q.ackv;
  assign o_ack_id = q.ack_id;
  assign o_prio_drop = q.drop;
  assign o_irq = q.irq;
  assign o_fast = q.fast;
  assign o_wake = q.wake;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ns_read_secure;
    i_acc_valid && !i_acc_write && !i_acc_secure && !acc_grp1;
  endsequence

  sequence s_ns_write_secure;
    i_acc_valid && i_acc_write && !i_acc_secure && acc_id_ok && !acc_grp1;
  endsequence

  a_ns_read_zero: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_ns_read_secure |=> o_acc_rdata == '0 && o_acc_rvalid)
    else $error("non-secure read leaked secure state");
  a_ns_write_keep: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_ns_write_secure |=> $stable(q.grp) && $stable(q.en) && $stable(q.edge_cfg)
      && $stable(q.tgt))
    else $error("non-secure write changed secure config");
  a_no_fast_grp1: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_cpu_en_grp0[0] && i_fast_en[0] && !hp0[0] |=> !o_fast[0])
    else $error("fast line raised without group 0 request");
  a_irq_nsec: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    hp1[0] && (i_cpu_en_grp0[0] || i_cpu_en_grp1[0]) |=> o_irq[0])
    else $error("group 1 request not on normal line");
  a_bypass_block: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_cpu_en_grp0[1] && !i_cpu_en_grp1[1] && i_irq_byp_dis[1] |=> !o_irq[1])
    else $error("legacy line bypassed while disabled");
  a_wake_sleep: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_cpu_sleep[1] && pend_any[1] |=> o_wake[1])
    else $error("no wakeup for sleeping processor");

endmodule

/* tb/igsf_cpu_model.sv */
// Processor-side model: issues field accesses and interrupt handshakes.
// Assumes one clock shared with the filter; the bench calls its tasks.
`timescale 1ns/1ps
module igsf_cpu_model import igsf_pkg::*; #(
  parameter int N_CPU = 2,
  parameter int CW = 1,
  parameter int IDW = 5,
  parameter int DW = 8
) (
  // Clock
  input logic i_clk_sys,
  // Field access
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic o_acc_secure,
  output igsf_fld_t o_acc_fld,
  output logic [CW-1:0] o_acc_cpu,
  output logic [IDW-1:0] o_acc_id,
  output logic [DW-1:0] o_acc_wdata,
  // Handshake
  output logic [N_CPU-1:0] o_ack,
  output logic [N_CPU-1:0] o_eoi,
  output logic [N_CPU-1:0] o_deact,
  output logic [N_CPU*IDW-1:0] o_eoi_id
);
  initial begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_secure = 1'b0;
    o_acc_fld = IGSF_FLD_GROUP;
    o_acc_cpu = '0;
    o_acc_id = '0;
    o_acc_wdata = '0;
    o_ack = '0;
    o_eoi = '0;
    o_deact = '0;
    o_eoi_id = '0;
  end

  // ****************************************
  // Field access
  // ****************************************
  task access(input logic wr, input logic sec, input igsf_fld_t fld,
      input logic [CW-1:0] cpu, input logic [IDW-1:0] id, input logic [DW-1:0] wd);
    @(posedge i_clk_sys);
    o_acc_valid <= 1'b1;
    o_acc_write <= wr;
    o_acc_secure <= sec;
    o_acc_fld <= fld;
    o_acc_cpu <= cpu;
    o_acc_id <= id;
    o_acc_wdata <= wd;
    @(posedge i_clk_sys);
    o_acc_valid <= 1'b0;
    // Released data shows no stale value
    o_acc_wdata <= ~wd;
  endtask

  // ****************************************
  // Handshake
  // ****************************************
  task ack(input int c);
    @(posedge i_clk_sys);
    o_ack[c] <= 1'b1;
    @(posedge i_clk_sys);
    o_ack[c] <= 1'b0;
  endtask

  // Completion, or deactivation when dct is set
  task done(input int c, input logic [IDW-1:0] id, input logic dct);
    @(posedge i_clk_sys);
    o_eoi_id[c*IDW +: IDW] <= id;
    o_deact[c] <= dct;
    o_eoi[c] <= ~dct;
    @(posedge i_clk_sys);
    o_eoi[c] <= 1'b0;
    o_deact[c] <= 1'b0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the interrupt group security filter.
// Assumes the processor model drives accesses and handshakes.
`timescale 1ns/1ps
module testbench import igsf_pkg::*; ;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] priv_src = '0;
  logic [7:0] spi_src = '0;
  logic [1:0] leg_irq = '0;
  logic [1:0] leg_fast = '0;
  logic dist_en = 1'b0;
  logic [1:0] en0 = '0;
  logic [1:0] en1 = '0;
  logic [1:0] fast_en = '0;
  logic [1:0] irq_bd = '0;
  logic [1:0] fast_bd = '0;
  logic [1:0] split = '0;
  logic [1:0] sleep = '0;
  logic acc_valid, acc_write, acc_secure, acc_cpu;
  igsf_fld_t acc_fld;
  logic [4:0] acc_id;
  logic [7:0] acc_wdata, rdata;
  logic [1:0] ack, eoi, deact, ack_valid, prio_drop, irq, fast, wake;
  logic [9:0] eoi_id, ack_id;
  logic rvalid;
  int mismatches = 0;
  int samples_checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  igsf_cpu_model u_igsf_cpu_model (.i_clk_sys(clk_sys), .o_acc_valid(acc_valid),
    .o_acc_write(acc_write), .o_acc_secure(acc_secure), .o_acc_fld(acc_fld),
    .o_acc_cpu(acc_cpu), .o_acc_id(acc_id), .o_acc_wdata(acc_wdata), .o_ack(ack),
    .o_eoi(eoi), .o_deact(deact), .o_eoi_id(eoi_id));

  igsf_filter u_igsf_filter (.i_clk_sys(clk_sys), .i_srst(srst), .i_priv_src(priv_src),
    .i_spi_src(spi_src), .i_legacy_irq(leg_irq), .i_legacy_fast(leg_fast),
    .i_dist_en(dist_en), .i_cpu_en_grp0(en0), .i_cpu_en_grp1(en1), .i_fast_en(fast_en),
    .i_irq_byp_dis(irq_bd), .i_fast_byp_dis(fast_bd), .i_eoi_split(split),
    .i_cpu_sleep(sleep), .i_acc_valid(acc_valid), .i_acc_write(acc_write),
    .i_acc_secure(acc_secure), .i_acc_fld(acc_fld), .i_acc_cpu(acc_cpu),
    .i_acc_id(acc_id), .i_acc_wdata(acc_wdata), .o_acc_rvalid(rvalid),
    .o_acc_rdata(rdata), .i_ack(ack), .o_ack_valid(ack_valid), .o_ack_id(ack_id),
    .i_eoi(eoi), .i_deact(deact), .i_eoi_id(eoi_id), .o_prio_drop(prio_drop),
    .o_irq(irq), .o_fast(fast), .o_wake(wake));

  // ****************************************
  // Compares and helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd(input int s, input igsf_fld_t f, input int c, input int id,
      input logic [7:0] e);
    u_igsf_cpu_model.access(1'b0, s[0], f, c[0], id[4:0], 8'h00);
    #1;
    chk1("rvalid", 1'b1, rvalid);
    chk("rdata", e, rdata);
  endtask
  task automatic wr(input int s, input igsf_fld_t f, input int c, input int id,
      input logic [7:0] d);
    u_igsf_cpu_model.access(1'b1, s[0], f, c[0], id[4:0], d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_filter();
    wr(1, IGSF_FLD_GROUP, 0, 5, 8'h01);
    rd(0, IGSF_FLD_GROUP, 0, 5, 8'h01);
    rd(0, IGSF_FLD_GROUP, 0, 4, 8'h00);
    wr(0, IGSF_FLD_ENABLE, 0, 4, 8'h01);
    rd(1, IGSF_FLD_ENABLE, 0, 4, 8'h00);
    wr(0, IGSF_FLD_GROUP, 0, 5, 8'h00);
    rd(1, IGSF_FLD_GROUP, 0, 5, 8'h01);
    wr(0, IGSF_FLD_ENABLE, 0, 5, 8'h01);
    rd(1, IGSF_FLD_ENABLE, 0, 5, 8'h01);
    wr(1, IGSF_FLD_ENABLE, 0, 4, 8'h01);
    rd(0, IGSF_FLD_ENABLE, 0, 4, 8'h00);
    rd(1, IGSF_FLD_ENABLE, 0, 4, 8'h01);
  endtask

  task automatic t_route();
    wr(1, IGSF_FLD_TARGET, 0, 4, 8'h01);
    wr(1, IGSF_FLD_TARGET, 0, 5, 8'h01);
    @(posedge clk_sys);
    dist_en <= 1'b1;
    en0 <= 2'b11;
    en1 <= 2'b11;
    fast_en <= 2'b01;
    spi_src[0] <= 1'b1;
    cyc(8);
    chk1("fast0", 1'b1, fast[0]);
    chk1("irq0", 1'b0, irq[0]);
    fast_en <= 2'b00;
    cyc(3);
    chk1("irq0", 1'b1, irq[0]);
    chk1("fast0", 1'b0, fast[0]);
    fast_en <= 2'b01;
    spi_src <= 8'h02;
    cyc(8);
    chk1("irq0", 1'b1, irq[0]);
    chk1("fast0", 1'b0, fast[0]);
    chk("cpu1", 8'h00, {6'h00, irq[1], fast[1]});
    spi_src <= 8'h00;
    cyc(8);
    chk1("irq0", 1'b0, irq[0]);
  endtask

  task automatic t_state();
    @(posedge clk_sys);
    spi_src[0] <= 1'b1;
    cyc(8);
    rd(1, IGSF_FLD_STATE, 0, 4, 8'h01);
    u_igsf_cpu_model.ack(0);
    #1;
    chk1("ack_valid", 1'b1, ack_valid[0]);
    chk("ack_id", 8'h04, {3'h0, ack_id[4:0]});
    rd(1, IGSF_FLD_STATE, 0, 4, 8'h03);
    @(posedge clk_sys);
    spi_src[0] <= 1'b0;
    cyc(8);
    rd(1, IGSF_FLD_STATE, 0, 4, 8'h02);
    u_igsf_cpu_model.done(0, 5'h04, 1'b0);
    #1;
    chk1("prio_drop", 1'b1, prio_drop[0]);
    rd(1, IGSF_FLD_STATE, 0, 4, 8'h00);
  endtask

  // Three-cycle pulse on shared source 2, then settle
  task automatic pulse_edge();
    @(posedge clk_sys);
    spi_src[2] <= 1'b1;
    cyc(3);
    spi_src[2] <= 1'b0;
    cyc(8);
  endtask

  task automatic t_edge_split();
    wr(1, IGSF_FLD_EDGE, 0, 6, 8'h01);
    wr(1, IGSF_FLD_ENABLE, 0, 6, 8'h01);
    wr(1, IGSF_FLD_TARGET, 0, 6, 8'h01);
    @(posedge clk_sys);
    split <= 2'b01;
    pulse_edge();
    rd(1, IGSF_FLD_STATE, 0, 6, 8'h01);
    u_igsf_cpu_model.ack(0);
    #1;
    chk("ack_id", 8'h06, {3'h0, ack_id[4:0]});
    u_igsf_cpu_model.done(0, 5'h06, 1'b0);
    #1;
    chk1("prio_drop", 1'b1, prio_drop[0]);
    rd(1, IGSF_FLD_STATE, 0, 6, 8'h02);
    pulse_edge();
    rd(1, IGSF_FLD_STATE, 0, 6, 8'h03);
    u_igsf_cpu_model.done(0, 5'h06, 1'b1);
    rd(1, IGSF_FLD_STATE, 0, 6, 8'h01);
    wr(1, IGSF_FLD_PEND_CLR, 0, 6, 8'h01);
    rd(1, IGSF_FLD_STATE, 0, 6, 8'h00);
  endtask

  task automatic t_sw();
    wr(1, IGSF_FLD_PEND_SET, 0, 8, 8'h01);
    rd(1, IGSF_FLD_PEND_SET, 0, 8, 8'h01);
    wr(1, IGSF_FLD_PEND_CLR, 0, 8, 8'h01);
    rd(1, IGSF_FLD_STATE, 0, 8, 8'h00);
    wr(1, IGSF_FLD_STATE, 0, 8, 8'h02);
    rd(1, IGSF_FLD_STATE, 0, 8, 8'h02);
    wr(0, IGSF_FLD_STATE, 0, 8, 8'h00);
    rd(1, IGSF_FLD_STATE, 0, 8, 8'h02);
    wr(1, IGSF_FLD_STATE, 0, 8, 8'h00);
  endtask

  task automatic t_scope();
    rd(1, IGSF_FLD_TARGET, 1, 1, 8'h02);
    wr(1, IGSF_FLD_ENABLE, 1, 1, 8'h01);
    wr(1, IGSF_FLD_TARGET, 0, 7, 8'h03);
    wr(1, IGSF_FLD_ENABLE, 0, 7, 8'h01);
    @(posedge clk_sys);
    priv_src[5] <= 1'b1;
    spi_src[3] <= 1'b1;
    sleep <= 2'b10;
    cyc(8);
    rd(1, IGSF_FLD_STATE, 1, 1, 8'h01);
    rd(1, IGSF_FLD_STATE, 0, 1, 8'h00);
    rd(1, IGSF_FLD_STATE, 0, 7, 8'h01);
    rd(1, IGSF_FLD_STATE, 1, 7, 8'h01);
    chk("wake", 8'h02, {6'h00, wake});
    @(posedge clk_sys);
    priv_src[5] <= 1'b0;
    spi_src[3] <= 1'b0;
    sleep <= 2'b00;
    cyc(8);
  endtask

  task automatic t_bypass();
    @(posedge clk_sys);
    en0 <= 2'b01;
    en1 <= 2'b01;
    leg_irq <= 2'b11;
    leg_fast <= 2'b10;
    cyc(6);
    chk("legacy", 8'h03, {6'h00, irq[1], fast[1]});
    chk1("irq0", 1'b0, irq[0]);
    irq_bd <= 2'b10;
    fast_bd <= 2'b10;
    cyc(3);
    chk("legacy", 8'h00, {6'h00, irq[1], fast[1]});
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("lines", 8'h00, {2'b00, irq, fast, wake});
    rd(1, IGSF_FLD_GROUP, 0, 4, 8'h00);
    t_filter();
    t_route();
    t_state();
    t_edge_split();
    t_sw();
    t_scope();
    t_bypass();
    end_sim();
  end

  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule
